// *** cmt_defines.vh ***
// constants for the colour matrix transform block: register map, fields, reset values, coefficients
`ifndef CMT_DEFINES_VH
`define CMT_DEFINES_VH

`define CMT_ADDR_W 8
`define CMT_ADDR_PIPE_CTRL 8'h00
`define CMT_ADDR_UNIT_SEL 8'h04
`define CMT_ADDR_XFORM_ON 8'h08
`define CMT_ADDR_COEFF_PICK 8'h0C
`define CMT_ADDR_COEFF_VALUE 8'h10
`define CMT_ADDR_ILLUM 8'h14
`define CMT_ADDR_RED_WB 8'h18
`define CMT_ADDR_BLUE_WB 8'h1C
`define CMT_ADDR_CHROMA 8'h20
`define CMT_ADDR_STATUS 8'h24

`define CMT_PIPE_ON_BIT 0
`define CMT_YUV_FMT_BIT 1
`define CMT_BOOST_ON_BIT 16
`define CMT_STAT_CSC_BIT 8
`define CMT_STAT_YUV_BIT 9

`define CMT_RESP_OKAY 2'b00
`define CMT_RESP_SLVERR 2'b10

`define CMT_NUM_COEFF 4'hC
`define CMT_PRESET_CUSTOM 3'h7
`define CMT_UNIT_CSC 1'b0
`define CMT_UNIT_YUV 1'b1

`define CMT_RST_PIPE_ON 1'b1
`define CMT_RST_CSC_ON 1'b1
`define CMT_RST_PRESET 3'h0
`define CMT_RST_BOOST_LEVEL 16'h1000

// signed q4.12: 16'h1000 is 1.0; bias 1.0 is full scale (256 levels)
`define CMT_ONE 16'h1000
`define CMT_ROUND 28'sh000_0800
`define CMT_FRAC 12
`define CMT_BIAS_SHIFT 8

// preset row: {red diag, blue diag, red wb ratio, blue wb ratio}
`define CMT_PRESET_0 64'h1600_1600_1400_1800
`define CMT_PRESET_1 64'h1300_1C00_1000_2400
`define CMT_PRESET_2 64'h1380_1A00_1100_2200
`define CMT_PRESET_3 64'h1480_1800_1300_1E00
`define CMT_PRESET_4 64'h1600_1600_1500_1A00
`define CMT_PRESET_5 64'h1700_1480_1700_1700
`define CMT_PRESET_6 64'h1800_1400_1900_1500

// rgb to luma/chroma, full-range
`define CMT_YUV_K00 16'h04C9
`define CMT_YUV_K01 16'h0964
`define CMT_YUV_K02 16'h01D3
`define CMT_YUV_K10 16'hFD4D
`define CMT_YUV_K11 16'hFAB3
`define CMT_YUV_K12 16'h0800
`define CMT_YUV_K20 16'h0800
`define CMT_YUV_K21 16'hF94D
`define CMT_YUV_K22 16'hFEB3
`define CMT_YUV_B0 16'h0000
`define CMT_YUV_B1 16'h0800
`define CMT_YUV_B2 16'h0800

`define CMT_FIFO_DEPTH 8
`define CMT_FIFO_AW 3
`define CMT_PIX_W 24

`endif

// *** cmt_color_matrix.v ***
// colour matrix transform stage: axi4-lite registers, matrix datapath and output fifo
// Function
// - each pixel's three outputs are the 3x3 matrix times input rgb plus an offset triplet.
// - coefficient index is output channel first then input r,g,b; bias n adds to output n.
// - there are two units, native_to_standard_rgb and rgb_to_luma_chroma, each with own matrix and offsets.
// - native_to_standard_rgb runs first, then the gamma stage, then rgb_to_luma_chroma.
// - transform_unit_select picks the unit that transform_on, coeff_pick and coeff_value address.
// - with native_to_standard_rgb selected, transform_on 0 bypasses that matrix and 1 applies it.
// - rgb_to_luma_chroma runs only when the output pixel format is a luma/chroma format.
// - with rgb_to_luma_chroma selected, transform_on is read-only and shows the format-derived state.
// - illuminant_preset loads the active native_to_standard_rgb matrix from calibrated presets.
// - user coefficients apply only when illuminant_preset is user_matrix_choice, via coeff_pick and coeff_value.
// - reading coeff_value returns the coefficient or bias in use at coeff_pick for either unit.
// - coeff_pick addresses one of nine coefficients or three bias terms of the selected unit.
// - coefficients and biases are fractional quantities, not integers.
// - choosing a preset also loads red_wb_ratio and blue_wb_ratio, which software may later overwrite.
// - chroma_boost_level saturation applies only while chroma_boost_on is 1; larger means more vivid.
// - colour controls are reachable only while image_pipe_on is set.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "cmt_defines.vh"

module cmt_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i,
  output wire [AW:0] count_o
);
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_o = (count != FULL_CNT);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // cmt_fifo

module cmt_color_matrix (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire [`CMT_ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`CMT_ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire pix_valid_i,
  input wire [`CMT_PIX_W-1:0] pix_data_i,
  output reg pix_ready_o,
  output reg gam_valid_o,
  output reg [`CMT_PIX_W-1:0] gam_data_o,
  input wire gam_ready_i,
  input wire gret_valid_i,
  input wire [`CMT_PIX_W-1:0] gret_data_i,
  output reg gret_ready_o,
  output reg out_valid_o,
  output reg [`CMT_PIX_W-1:0] out_data_o,
  input wire out_ready_i
);
  reg image_pipe_on;
  reg yuv_fmt;
  reg transform_unit_select;
  reg csc_on;
  reg chroma_boost_on;
  reg [15:0] chroma_boost_level;
  reg [3:0] coeff_pick;
  reg [2:0] illuminant_preset;
  reg [15:0] red_wb_ratio;
  reg [15:0] blue_wb_ratio;
  reg [15:0] user_coeff [0:11];
  reg [15:0] csc_m [0:11];
  reg [15:0] yuv_m [0:11];
  reg [`CMT_PIX_W-1:0] next_gam_data;
  reg [`CMT_PIX_W-1:0] next_b_data;
  reg [7:0] csc_px [0:2];
  reg [9:0] luma_sum;
  reg b_valid;
  reg [`CMT_PIX_W-1:0] b_data;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`CMT_PIX_W-1:0] fifo_out_data;
  wire [`CMT_FIFO_AW:0] fifo_count;
  wire fifo_pop;
  wire take_a;
  wire take_b;
  wire wr_go;
  wire rd_go;
  wire wr_err;
  wire rd_err;
  wire [31:0] wmask;
  wire [31:0] wval;
  wire user_mode;
  integer i;
  integer k;
  integer m;
  localparam [63:0] RST_WB_ROW = `CMT_PRESET_0;
  wire [31:0] wb_pick;

  // signed q4.12 dot product of three pixels plus bias, rounded and clamped to 8 bits
  function [7:0] cmt_clamp;
    input signed [27:0] acc;
    begin
      if (acc < 0) begin
        cmt_clamp = 8'h00;
      end else if (acc[27:`CMT_FRAC] > 16'h00FF) begin
        cmt_clamp = 8'hFF;
      end else begin
        cmt_clamp = acc[`CMT_FRAC+7:`CMT_FRAC];
      end
    end
  endfunction

  function [7:0] cmt_mac;
    input [15:0] k0;
    input [15:0] k1;
    input [15:0] k2;
    input [15:0] bias;
    input [7:0] p0;
    input [7:0] p1;
    input [7:0] p2;
    reg signed [27:0] acc;
    begin
      acc = $signed(k0) * $signed({1'b0, p0}) + $signed(k1) * $signed({1'b0, p1})
          + $signed(k2) * $signed({1'b0, p2}) + ($signed(bias) <<< `CMT_BIAS_SHIFT) + `CMT_ROUND;
      cmt_mac = cmt_clamp(acc);
    end
  endfunction

  function [7:0] cmt_boost;
    input [7:0] c;
    input [7:0] luma;
    input [15:0] level;
    reg signed [27:0] acc;
    begin
      // pushes each channel away from luma; level 1.0 leaves the pixel unchanged
      acc = ($signed({2'b00, c}) - $signed({2'b00, luma})) * $signed(level)
          + $signed({8'h00, luma, 12'h000}) + `CMT_ROUND;
      cmt_boost = cmt_clamp(acc);
    end
  endfunction

  function [15:0] cmt_preset_coeff;
    input [2:0] preset;
    input [3:0] idx;
    reg [63:0] row;
    reg [15:0] rd;
    reg [15:0] bd;
    reg [15:0] ro;
    reg [15:0] bo;
    begin
      case (preset)
        3'h0: row = `CMT_PRESET_0;
        3'h1: row = `CMT_PRESET_1;
        3'h2: row = `CMT_PRESET_2;
        3'h3: row = `CMT_PRESET_3;
        3'h4: row = `CMT_PRESET_4;
        3'h5: row = `CMT_PRESET_5;
        3'h6: row = `CMT_PRESET_6;
        default: row = {`CMT_ONE, `CMT_ONE, `CMT_ONE, `CMT_ONE};
      endcase
      rd = row[63:48];
      bd = row[47:32];
      // off-diagonals split the excess so every row still sums to 1.0 (neutral grey stays grey)
      ro = `CMT_ONE - rd;
      ro = {ro[15], ro[15:1]};
      bo = `CMT_ONE - bd;
      bo = {bo[15], bo[15:1]};
      case (idx)
        4'h0: cmt_preset_coeff = rd;
        4'h1: cmt_preset_coeff = ro;
        4'h2: cmt_preset_coeff = ro;
        4'h4: cmt_preset_coeff = `CMT_ONE;
        4'h6: cmt_preset_coeff = bo;
        4'h7: cmt_preset_coeff = bo;
        4'h8: cmt_preset_coeff = bd;
        default: cmt_preset_coeff = 16'h0000;
      endcase
    end
  endfunction

  function [31:0] cmt_preset_wb;
    input [2:0] preset;
    reg [63:0] row;
    begin
      case (preset)
        3'h0: row = `CMT_PRESET_0;
        3'h1: row = `CMT_PRESET_1;
        3'h2: row = `CMT_PRESET_2;
        3'h3: row = `CMT_PRESET_3;
        3'h4: row = `CMT_PRESET_4;
        3'h5: row = `CMT_PRESET_5;
        default: row = `CMT_PRESET_6;
      endcase
      cmt_preset_wb = row[31:0];
    end
  endfunction

  assign user_mode = (illuminant_preset == `CMT_PRESET_CUSTOM);

  always @* begin
    for (i = 0; i < 12; i = i + 1) begin
      csc_m[i] = user_mode ? user_coeff[i] : cmt_preset_coeff(illuminant_preset, i[3:0]);
    end
    yuv_m[0] = `CMT_YUV_K00;
    yuv_m[1] = `CMT_YUV_K01;
    yuv_m[2] = `CMT_YUV_K02;
    yuv_m[3] = `CMT_YUV_K10;
    yuv_m[4] = `CMT_YUV_K11;
    yuv_m[5] = `CMT_YUV_K12;
    yuv_m[6] = `CMT_YUV_K20;
    yuv_m[7] = `CMT_YUV_K21;
    yuv_m[8] = `CMT_YUV_K22;
    yuv_m[9] = `CMT_YUV_B0;
    yuv_m[10] = `CMT_YUV_B1;
    yuv_m[11] = `CMT_YUV_B2;
  end

  // first stage: native to standard rgb, then saturation
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      if (csc_on) begin
        csc_px[k] = cmt_mac(csc_m[3*k], csc_m[3*k+1], csc_m[3*k+2], csc_m[9+k],
                            pix_data_i[23:16], pix_data_i[15:8], pix_data_i[7:0]);
      end else begin
        csc_px[k] = pix_data_i[23-8*k -: 8];
      end
    end
    luma_sum = {2'b00, csc_px[0]} + {1'b0, csc_px[1], 1'b0} + {2'b00, csc_px[2]};
    if (chroma_boost_on) begin
      next_gam_data = {cmt_boost(csc_px[0], luma_sum[9:2], chroma_boost_level),
                       cmt_boost(csc_px[1], luma_sum[9:2], chroma_boost_level),
                       cmt_boost(csc_px[2], luma_sum[9:2], chroma_boost_level)};
    end else begin
      next_gam_data = {csc_px[0], csc_px[1], csc_px[2]};
    end
  end

  // second stage sits after the external gamma loop
  always @* begin
    if (yuv_fmt) begin
      next_b_data = {cmt_mac(yuv_m[0], yuv_m[1], yuv_m[2], yuv_m[9],
                             gret_data_i[23:16], gret_data_i[15:8], gret_data_i[7:0]),
                     cmt_mac(yuv_m[3], yuv_m[4], yuv_m[5], yuv_m[10],
                             gret_data_i[23:16], gret_data_i[15:8], gret_data_i[7:0]),
                     cmt_mac(yuv_m[6], yuv_m[7], yuv_m[8], yuv_m[11],
                             gret_data_i[23:16], gret_data_i[15:8], gret_data_i[7:0])};
    end else begin
      next_b_data = gret_data_i;
    end
  end

  // the two register stages before the fifo take a pixel only while empty: half rate, but both readies are flops
  assign take_a = pix_valid_i & pix_ready_o;
  assign take_b = gret_valid_i & gret_ready_o;
  assign fifo_pop = fifo_out_valid & (~out_valid_o | out_ready_i);

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gam_valid_o <= 1'b0;
      gam_data_o <= {`CMT_PIX_W{1'b0}};
      pix_ready_o <= 1'b0;
      b_valid <= 1'b0;
      b_data <= {`CMT_PIX_W{1'b0}};
      gret_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= {`CMT_PIX_W{1'b0}};
    end else begin
      if (take_a) begin
        gam_valid_o <= 1'b1;
        gam_data_o <= next_gam_data;
      end else if (gam_valid_o && gam_ready_i) begin
        gam_valid_o <= 1'b0;
      end
      pix_ready_o <= ~(take_a | (gam_valid_o & ~gam_ready_i));
      if (take_b) begin
        b_valid <= 1'b1;
        b_data <= next_b_data;
      end else if (b_valid && fifo_in_ready) begin
        b_valid <= 1'b0;
      end
      gret_ready_o <= ~(take_b | (b_valid & ~fifo_in_ready));
      if (fifo_pop) begin
        out_valid_o <= 1'b1;
        out_data_o <= fifo_out_data;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

  cmt_fifo #(
    .WIDTH(`CMT_PIX_W),
    .DEPTH(`CMT_FIFO_DEPTH),
    .AW(`CMT_FIFO_AW)
  ) u_out_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(b_valid),
    .in_data_i(b_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_pop),
    .count_o(fifo_count)
  );

  // register read view; also the old value for byte-strobe merging
  function [31:0] cmt_reg_view;
    input [`CMT_ADDR_W-1:0] addr;
    reg [15:0] sel;
    begin
      sel = transform_unit_select ? yuv_m[coeff_pick] : csc_m[coeff_pick];
      case (addr)
        `CMT_ADDR_PIPE_CTRL: cmt_reg_view = {30'h0000_0000, yuv_fmt, image_pipe_on};
        `CMT_ADDR_UNIT_SEL: cmt_reg_view = {31'h0000_0000, transform_unit_select};
        `CMT_ADDR_XFORM_ON: cmt_reg_view = {31'h0000_0000, transform_unit_select ? yuv_fmt : csc_on};
        `CMT_ADDR_COEFF_PICK: cmt_reg_view = {28'h000_0000, coeff_pick};
        `CMT_ADDR_COEFF_VALUE: cmt_reg_view = {{16{sel[15]}}, sel};
        `CMT_ADDR_ILLUM: cmt_reg_view = {29'h0000_0000, illuminant_preset};
        `CMT_ADDR_RED_WB: cmt_reg_view = {16'h0000, red_wb_ratio};
        `CMT_ADDR_BLUE_WB: cmt_reg_view = {16'h0000, blue_wb_ratio};
        `CMT_ADDR_CHROMA: cmt_reg_view = {15'h0000, chroma_boost_on, chroma_boost_level};
        `CMT_ADDR_STATUS: cmt_reg_view = {22'h00_0000, yuv_fmt, csc_on, 4'h0, fifo_count};
        default: cmt_reg_view = 32'h0000_0000;
      endcase
    end
  endfunction

  function cmt_addr_err;
    input [`CMT_ADDR_W-1:0] addr;
    input pipe_on;
    begin
      if (addr > `CMT_ADDR_STATUS || addr[1:0] != 2'b00) begin
        cmt_addr_err = 1'b1;
      end else if (addr == `CMT_ADDR_PIPE_CTRL || addr == `CMT_ADDR_STATUS) begin
        cmt_addr_err = 1'b0;
      end else begin
        cmt_addr_err = ~pipe_on;
      end
    end
  endfunction

  assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o & ~s_axi_bvalid_o;
  assign rd_go = s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
  assign wr_err = cmt_addr_err(s_axi_awaddr_i, image_pipe_on);
  assign rd_err = cmt_addr_err(s_axi_araddr_i, image_pipe_on);
  assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}}, {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  assign wval = (cmt_reg_view(s_axi_awaddr_i) & ~wmask) | (s_axi_wdata_i & wmask);
  assign wb_pick = cmt_preset_wb(wval[2:0]);

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CMT_RESP_OKAY;
      image_pipe_on <= `CMT_RST_PIPE_ON;
      yuv_fmt <= 1'b0;
      transform_unit_select <= `CMT_UNIT_CSC;
      csc_on <= `CMT_RST_CSC_ON;
      coeff_pick <= 4'h0;
      illuminant_preset <= `CMT_RST_PRESET;
      red_wb_ratio <= RST_WB_ROW[31:16];
      blue_wb_ratio <= RST_WB_ROW[15:0];
      chroma_boost_on <= 1'b0;
      chroma_boost_level <= `CMT_RST_BOOST_LEVEL;
      for (m = 0; m < 12; m = m + 1) begin
        user_coeff[m] <= (m == 0 || m == 4 || m == 8) ? `CMT_ONE : 16'h0000;
      end
    end else begin
      s_axi_awready_o <= wr_go;
      s_axi_wready_o <= wr_go;
      if (wr_go) begin
        s_axi_bresp_o <= wr_err ? `CMT_RESP_SLVERR : `CMT_RESP_OKAY;
      end
      // response only after the address/data handshake edge
      if (s_axi_awready_o) begin
        s_axi_bvalid_o <= 1'b1;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (wr_go && !wr_err) begin
        case (s_axi_awaddr_i)
          `CMT_ADDR_PIPE_CTRL: begin
            image_pipe_on <= wval[`CMT_PIPE_ON_BIT];
            yuv_fmt <= wval[`CMT_YUV_FMT_BIT];
          end
          `CMT_ADDR_UNIT_SEL: transform_unit_select <= wval[0];
          `CMT_ADDR_XFORM_ON: begin
            if (transform_unit_select == `CMT_UNIT_CSC) begin
              csc_on <= wval[0];
            end
          end
          `CMT_ADDR_COEFF_PICK: begin
            if (wval[3:0] < `CMT_NUM_COEFF) begin
              coeff_pick <= wval[3:0];
            end
          end
          `CMT_ADDR_COEFF_VALUE: begin
            // luma/chroma matrix is fixed; its values are readable only
            if (transform_unit_select == `CMT_UNIT_CSC) begin
              user_coeff[coeff_pick] <= wval[15:0];
            end
          end
          `CMT_ADDR_ILLUM: begin
            illuminant_preset <= wval[2:0];
            if (wval[2:0] != `CMT_PRESET_CUSTOM) begin
              red_wb_ratio <= wb_pick[31:16];
              blue_wb_ratio <= wb_pick[15:0];
            end
          end
          `CMT_ADDR_RED_WB: red_wb_ratio <= wval[15:0];
          `CMT_ADDR_BLUE_WB: blue_wb_ratio <= wval[15:0];
          `CMT_ADDR_CHROMA: begin
            chroma_boost_on <= wval[`CMT_BOOST_ON_BIT];
            chroma_boost_level <= wval[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `CMT_RESP_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
    end else begin
      s_axi_arready_o <= rd_go;
      if (rd_go) begin
        s_axi_rresp_o <= rd_err ? `CMT_RESP_SLVERR : `CMT_RESP_OKAY;
        s_axi_rdata_o <= rd_err ? 32'h0000_0000 : cmt_reg_view(s_axi_araddr_i);
      end
      if (s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule // cmt_color_matrix

// *** cmt_color_matrix_checker.sv ***
// handshake and stream timing assertions for the colour matrix block
`timescale 1ns/10ps
`include "cmt_defines.vh"
module cmt_color_matrix_checker (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_wvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire pix_valid_i,
  input wire pix_ready_o,
  input wire gam_valid_o,
  input wire [`CMT_PIX_W-1:0] gam_data_o,
  input wire gam_ready_i,
  input wire gret_valid_i,
  input wire gret_ready_o,
  input wire out_valid_o,
  input wire [`CMT_PIX_W-1:0] out_data_o,
  input wire out_ready_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o && !s_axi_bvalid_o
    |=> s_axi_awready_o && s_axi_wready_o ##1 s_axi_bvalid_o) else $error("write not answered");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped early");
  a_read_answer: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
    |=> s_axi_arready_o ##1 s_axi_rvalid_o) else $error("read not answered");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("rvalid dropped early");
  a_pix_take: assert property (pix_valid_i && pix_ready_o |=> gam_valid_o && !pix_ready_o)
    else $error("pixel take not followed by gamma output");
  a_gam_held: assert property (gam_valid_o && !gam_ready_i |=> gam_valid_o && $stable(gam_data_o))
    else $error("gamma output changed while stalled");
  a_gret_pace: assert property (gret_valid_i && gret_ready_o |=> !gret_ready_o)
    else $error("gamma return accepted twice in a row");
  a_out_held: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("output changed while stalled");
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_pixel: cover property (out_valid_o && out_ready_i);
  c_stall: cover property (out_valid_o && !out_ready_i [*4]);
endmodule // cmt_color_matrix_checker

bind cmt_color_matrix cmt_color_matrix_checker cmt_color_matrix_checker_i (.*);

// *** cmt_gamma_model.sv ***
// stand-in for the external gamma stage: identity curve, one pixel in flight
`timescale 1ns/10ps
`include "cmt_defines.vh"
module cmt_gamma_model (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire stall_i,
  input wire gam_valid_i,
  input wire [`CMT_PIX_W-1:0] gam_data_i,
  output wire gam_ready_o,
  output reg gret_valid_o,
  output reg [`CMT_PIX_W-1:0] gret_data_o,
  input wire gret_ready_i
);
  assign gam_ready_o = !gret_valid_o && !stall_i;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gret_valid_o <= 1'b0;
      gret_data_o <= 24'h00_0000;
    end else if (gam_valid_i && gam_ready_o) begin
      gret_valid_o <= 1'b1;
      gret_data_o <= gam_data_i;
    end else if (gret_valid_o && gret_ready_i) begin
      gret_valid_o <= 1'b0;
      // released lines show the inverse so stale data cannot pass for valid
      gret_data_o <= ~gret_data_o;
    end
  end
endmodule // cmt_gamma_model

// *** tb.sv ***
// self-checking bench for the colour matrix transform block
`timescale 1ns/10ps
`include "cmt_defines.vh"
module tb;
  reg clk, rst_n, awv, wv, bre, arv, rre, pv, ore, gst;
  reg [7:0] awa, ara;
  reg [31:0] wd, rv;
  reg [23:0] pd;
  wire awr, wrd, bv, arr, rvl, pr, gv, gr, grv, grr, ov;
  wire [1:0] br, rr;
  wire [31:0] rdd;
  wire [23:0] gd, grd, od;
  integer fail_count, num_checks, i, j;
  cmt_color_matrix cmt_color_matrix_i (.sys_clk_i(clk), .rstn_i(rst_n), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rvl), .s_axi_rready_i(rre),
    .pix_valid_i(pv), .pix_data_i(pd), .pix_ready_o(pr), .gam_valid_o(gv), .gam_data_o(gd),
    .gam_ready_i(gr), .gret_valid_i(grv), .gret_data_i(grd), .gret_ready_o(grr),
    .out_valid_o(ov), .out_data_o(od), .out_ready_i(ore));
  cmt_gamma_model cmt_gamma_model_i (.sys_clk_i(clk), .rstn_i(rst_n), .stall_i(gst), .gam_valid_i(gv),
    .gam_data_i(gd), .gam_ready_o(gr), .gret_valid_o(grv), .gret_data_o(grd), .gret_ready_i(grr));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    integer n;
    begin
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      n = 0;
      while (bv !== 1'b1 && n < 200) begin
        @(posedge clk);
        if (awr === 1'b1) awv <= 1'b0;
        if (wrd === 1'b1) wv <= 1'b0;
        n = n + 1;
      end
      bre <= 1'b0;
      chk(bv, 1'b1);
      chk(br, e);
    end
  endtask
  task rd(input [7:0] a, input [1:0] e, output [31:0] q);
    integer n;
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      n = 0;
      while (rvl !== 1'b1 && n < 200) begin
        @(posedge clk);
        if (arr === 1'b1) arv <= 1'b0;
        n = n + 1;
      end
      q = rdd;
      chk(rvl, 1'b1);
      rre <= 1'b0;
      chk(rr, e);
    end
  endtask
  task w(input [7:0] a, input [31:0] d);
    wr(a, d, `CMT_RESP_OKAY);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a, `CMT_RESP_OKAY, rv);
      chk(rv, e);
    end
  endtask
  task snd(input [23:0] d);
    integer n;
    begin
      @(posedge clk);
      pd <= d;
      pv <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pr !== 1'b1 && n < 500);
      pv <= 1'b0;
      chk(pr, 1'b1);
      // idle data lines carry the inverse, not the last pixel
      pd <= ~d;
    end
  endtask
  task rcv(input [23:0] e);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (!(ov === 1'b1 && ore === 1'b1) && n < 500);
      chk(ov, 1'b1);
      chk(od, e);
    end
  endtask
  task px(input [23:0] d, input [23:0] e);
    begin
      snd(d);
      rcv(e);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
  initial begin
    fail_count = 0;
    num_checks = 0;
    {rst_n, awv, wv, bre, arv, rre, pv, gst} = 8'h00;
    ore = 1'b1;
    {awa, ara, wd, pd} = 72'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(`CMT_ADDR_ILLUM, 32'h0000_0000);
    rc(`CMT_ADDR_RED_WB, 32'h0000_1400);
    rc(`CMT_ADDR_BLUE_WB, 32'h0000_1800);
    w(`CMT_ADDR_ILLUM, 32'h0000_0001);
    rc(`CMT_ADDR_RED_WB, 32'h0000_1000);
    rc(`CMT_ADDR_BLUE_WB, 32'h0000_2400);
    w(`CMT_ADDR_RED_WB, 32'h0000_1234);
    rc(`CMT_ADDR_RED_WB, 32'h0000_1234);
    w(`CMT_ADDR_ILLUM, 32'h0000_0000);
    w(`CMT_ADDR_COEFF_PICK, 32'h0000_0001);
    rc(`CMT_ADDR_COEFF_VALUE, 32'hFFFF_FD00);
    w(`CMT_ADDR_COEFF_VALUE, 32'h0000_1000);
    rc(`CMT_ADDR_COEFF_VALUE, 32'hFFFF_FD00);
    w(`CMT_ADDR_ILLUM, {29'h0, `CMT_PRESET_CUSTOM});
    rc(`CMT_ADDR_COEFF_VALUE, 32'h0000_1000);
    w(`CMT_ADDR_COEFF_PICK, 32'h0000_0009);
    w(`CMT_ADDR_COEFF_VALUE, 32'h0000_0010);
    w(`CMT_ADDR_COEFF_PICK, 32'h0000_000C);
    rc(`CMT_ADDR_COEFF_PICK, 32'h0000_0009);
    px(24'h12_3456, 24'h47_3456);
    px(24'hF0_8001, 24'hFF_8001);
    w(`CMT_ADDR_XFORM_ON, 32'h0000_0000);
    px(24'h12_3456, 24'h12_3456);
    rc(`CMT_ADDR_STATUS, 32'h0000_0000);
    w(`CMT_ADDR_CHROMA, 32'h0001_2000);
    px(24'h60_4020, 24'h80_4000);
    w(`CMT_ADDR_CHROMA, 32'h0000_2000);
    px(24'h60_4020, 24'h60_4020);
    w(`CMT_ADDR_UNIT_SEL, 32'h0000_0001);
    w(`CMT_ADDR_XFORM_ON, 32'h0000_0001);
    rc(`CMT_ADDR_XFORM_ON, 32'h0000_0000);
    w(`CMT_ADDR_PIPE_CTRL, 32'h0000_0003);
    rc(`CMT_ADDR_XFORM_ON, 32'h0000_0001);
    rc(`CMT_ADDR_STATUS, 32'h0000_0200);
    w(`CMT_ADDR_COEFF_PICK, 32'h0000_0000);
    rc(`CMT_ADDR_COEFF_VALUE, 32'h0000_04C9);
    w(`CMT_ADDR_COEFF_VALUE, 32'h0000_1234);
    rc(`CMT_ADDR_COEFF_VALUE, 32'h0000_04C9);
    px(24'hFF_0000, 24'h4C_55FF);
    w(`CMT_ADDR_PIPE_CTRL, 32'h0000_0002);
    wr(`CMT_ADDR_ILLUM, 32'h0000_0003, `CMT_RESP_SLVERR);
    rd(`CMT_ADDR_ILLUM, `CMT_RESP_SLVERR, rv);
    chk(rv, 32'h0000_0000);
    wr(8'h28, 32'h0000_0000, `CMT_RESP_SLVERR);
    w(`CMT_ADDR_PIPE_CTRL, 32'h0000_0001);
    rc(`CMT_ADDR_ILLUM, 32'h0000_0007);
    // hold the sink and stall the gamma stage so the fifo fills to its limit
    ore <= 1'b0;
    gst <= 1'b1;
    fork
      for (i = 0; i < 9; i = i + 1) snd(24'h01_0203 * i);
    join_none
    repeat (20) @(posedge clk);
    gst <= 1'b0;
    repeat (80) @(posedge clk);
    rc(`CMT_ADDR_STATUS, 32'h0000_0008);
    ore <= 1'b1;
    for (j = 0; j < 9; j = j + 1) rcv(24'h01_0203 * j);
    report_and_stop;
  end
endmodule // tb
